// ==== cbm_pkg.sv ====
// ==========================================================
// Cache block management package
// ==========================================================
package cbm_pkg;

    // ==========================================================
    // Register map and reset values
    // ==========================================================
    localparam logic [7:0] CBM_OFF_ADDR = 8'h00;   // Effective address
    localparam logic [7:0] CBM_OFF_ATTR = 8'h04;   // Page attributes and checks
    localparam logic [7:0] CBM_OFF_CMD = 8'h08;    // Operation start
    localparam logic [7:0] CBM_OFF_STAT = 8'h0c;   // Status, done is write-one-clear
    localparam logic [31:0] CBM_ADDR_RESET = 32'h0000_0000;
    localparam logic [8:0] CBM_ATTR_RESET = 9'h000;
    localparam int CBM_ATTR_W = 9;
    localparam int CBM_BLOCK_BYTES = 32;           // Default block size

    // Status bit positions
    localparam int CBM_ST_BUSY = 0;
    localparam int CBM_ST_DONE = 1;
    localparam int CBM_ST_DSI = 2;
    localparam int CBM_ST_ALIGN = 3;
    localparam int CBM_ST_NOOP = 4;
    localparam int CBM_ST_WROTE = 5;
    localparam int CBM_ST_RCSTORE = 6;
    localparam int CBM_ST_W = 7;
    localparam logic [6:0] CBM_STAT_RESET = 7'h00;

    // ==========================================================
    // Operations and commands
    // ==========================================================
    typedef enum logic [2:0] {
        CBM_OP_TOUCH_LD = 3'h0,
        CBM_OP_TOUCH_ST = 3'h1,
        CBM_OP_ZERO = 3'h2,
        CBM_OP_STORE = 3'h3,
        CBM_OP_FLUSH = 3'h4,
        CBM_OP_ICBI = 3'h5,
        CBM_OP_ISYNC = 3'h6
    } cbm_op_type;
    localparam logic [2:0] CBM_OP_LAST = 3'h6;

    // Local data cache commands
    typedef enum logic [2:0] {
        CBM_DC_NONE = 3'h0,
        CBM_DC_LOOKUP = 3'h1,
        CBM_DC_PREFETCH = 3'h2,
        CBM_DC_ZERO = 3'h3,
        CBM_DC_ALLOC_ZERO = 3'h4,
        CBM_DC_CLEAN = 3'h5,
        CBM_DC_INV = 3'h6,
        CBM_DC_FLUSH = 3'h7
    } cbm_dc_cmd_type;

    // Broadcast commands to other processors
    typedef enum logic [2:0] {
        CBM_COH_NONE = 3'h0,
        CBM_COH_KILL = 3'h1,
        CBM_COH_CLEAN = 3'h2,
        CBM_COH_FLUSH = 3'h3,
        CBM_COH_ICINV = 3'h4
    } cbm_coh_cmd_type;

    // One-hot sequencer states
    typedef enum logic [7:0] {
        CBM_S_IDLE = 8'h01,
        CBM_S_ENTRY = 8'h02,
        CBM_S_LOOK = 8'h04,
        CBM_S_LOCAL = 8'h08,
        CBM_S_COH = 8'h10,
        CBM_S_MEM = 8'h20,
        CBM_S_SYNC = 8'h40,
        CBM_S_DONE = 8'h80
    } cbm_state_type;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic align_mode;  // 1: inhibited or write-through zero raises alignment
        logic unified;     // Unified cache build
        logic store_ok;    // Translation allows stores
        logic load_ok;     // Translation allows loads
        logic xlate_ok;    // Translation found
        logic seg_type;    // Segment type bit, 1 is direct-store
        logic m;           // Coherency required
        logic i;           // Caching inhibited
        logic w;           // Write-through
    } cbm_attr_type;

    typedef struct packed {
        logic hit;
        logic modified;
    } cbm_dc_resp_type;

endpackage

// ==== cbm_block_ops.sv ====
`timescale 1ns/1ps
module cbm_block_ops
    import cbm_pkg::*;
#(
    parameter int BLOCK_BYTES = CBM_BLOCK_BYTES,
    parameter bit PREFETCH_EN = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pipe_drained,
    output logic hold_issue,
    output logic fetch_discard,
    output logic [31:0] blk_addr,
    output logic dc_req,
    output cbm_dc_cmd_type dc_cmd,
    input wire logic dc_ack,
    input wire cbm_dc_resp_type dc_resp,
    output logic ic_inv_req,
    input wire logic ic_ack,
    output logic coh_req,
    output cbm_coh_cmd_type coh_cmd,
    input wire logic coh_ack,
    input wire logic coh_mod,
    output logic mem_zero_req,
    input wire logic mem_ack,
    output logic rc_rec,
    output logic rc_store
);

    // ==========================================================
    // Declarations
    // ==========================================================
    localparam logic [31:0] BLK_MASK = 32'(BLOCK_BYTES - 1);

    logic [31:0] addr_reg;         // Software effective address
    cbm_attr_type attr_reg;        // Software attributes
    logic [6:0] stat_reg;          // Status flags
    cbm_state_type state_reg;      // Sequencer state
    cbm_op_type op_reg;            // Operation in flight
    cbm_attr_type cur_attr_reg;    // Attributes frozen at start
    logic access;                  // Completing APB edge
    logic wr_fire;                 // Write takes effect
    logic start_cmd;               // Accepted operation start
    logic done_clr;                // Software clears done
    logic need_coh;                // Broadcast needed after local part
    cbm_coh_cmd_type coh_sel;      // Broadcast to issue
    logic mapped;                  // Address decodes
    logic [31:0] rdata_next;       // Read mux

    // ==========================================================
    // APB decode
    // ==========================================================
    // Completion happens on the second access cycle
    assign access = psel & penable & pready;
    assign wr_fire = access & pwrite;
    assign start_cmd = wr_fire & (paddr == CBM_OFF_CMD) & ~pslverr;
    assign done_clr = wr_fire & (paddr == CBM_OFF_STAT) & pwdata[CBM_ST_DONE];
    assign mapped = (paddr == CBM_OFF_ADDR) | (paddr == CBM_OFF_ATTR)
                  | (paddr == CBM_OFF_CMD) | (paddr == CBM_OFF_STAT);

    // Read data mux, unused bits read zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            CBM_OFF_ADDR: rdata_next = addr_reg;
            CBM_OFF_ATTR: rdata_next = {23'h000000, attr_reg};
            CBM_OFF_CMD: rdata_next = {29'h00000000, op_reg};
            CBM_OFF_STAT: rdata_next = {25'h0000000, stat_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // One wait state so every bus output comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready)
            begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_next;
                // Unmapped, start while busy, or unknown op is refused
                pslverr <= ~mapped
                         | (pwrite & (paddr == CBM_OFF_CMD)
                            & (stat_reg[CBM_ST_BUSY] | (pwdata[2:0] > CBM_OP_LAST)));
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    // Address and attributes may change while busy; the sequencer froze its copy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg <= CBM_ADDR_RESET;
            attr_reg <= cbm_attr_type'(CBM_ATTR_RESET);
        end
        else if (wr_fire)
        begin
            if (paddr == CBM_OFF_ADDR)
            begin
                addr_reg <= pwdata;
            end
            if (paddr == CBM_OFF_ATTR)
            begin
                attr_reg <= cbm_attr_type'(pwdata[CBM_ATTR_W-1:0]);
            end
        end
    end

    // ==========================================================
    // Broadcast selection
    // ==========================================================
    // coherency attribute gates broadcast
    always_comb
    begin
        coh_sel = CBM_COH_NONE;
        case (op_reg)
            CBM_OP_ZERO: coh_sel = CBM_COH_KILL;
            CBM_OP_STORE: coh_sel = CBM_COH_CLEAN;
            CBM_OP_FLUSH: coh_sel = CBM_COH_FLUSH;
            CBM_OP_ICBI: coh_sel = CBM_COH_ICINV;
            default: coh_sel = CBM_COH_NONE;
        endcase
        need_coh = cur_attr_reg.m & (coh_sel != CBM_COH_NONE);
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Requests are one-cycle pulses; partners answer with one-cycle acks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= CBM_S_IDLE;
            op_reg <= CBM_OP_TOUCH_LD;
            cur_attr_reg <= cbm_attr_type'(CBM_ATTR_RESET);
            stat_reg <= CBM_STAT_RESET;
            blk_addr <= 32'h0000_0000;
            dc_req <= 1'b0;
            dc_cmd <= CBM_DC_NONE;
            ic_inv_req <= 1'b0;
            coh_req <= 1'b0;
            coh_cmd <= CBM_COH_NONE;
            mem_zero_req <= 1'b0;
            rc_rec <= 1'b0;
            rc_store <= 1'b0;
            hold_issue <= 1'b0;
            fetch_discard <= 1'b0;
        end
        else
        begin
            dc_req <= 1'b0;
            ic_inv_req <= 1'b0;
            coh_req <= 1'b0;
            mem_zero_req <= 1'b0;
            rc_rec <= 1'b0;
            fetch_discard <= 1'b0;
            // Clear of done loses to a completion in the same cycle
            if (done_clr)
            begin
                stat_reg[CBM_ST_DONE] <= 1'b0;
            end
            case (state_reg)
                CBM_S_IDLE:
                begin
                    if (start_cmd)
                    begin
                        op_reg <= cbm_op_type'(pwdata[2:0]);
                        cur_attr_reg <= attr_reg;
                        blk_addr <= addr_reg & ~BLK_MASK;
                        stat_reg <= CBM_STAT_RESET;
                        stat_reg[CBM_ST_BUSY] <= 1'b1;
                        state_reg <= CBM_S_ENTRY;
                    end
                end
                CBM_S_ENTRY:
                begin
                    if (cur_attr_reg.seg_type)
                    begin
                        stat_reg[CBM_ST_NOOP] <= 1'b1;
                        state_reg <= CBM_S_DONE;
                    end
                    else
                    begin
                        case (op_reg)
                            CBM_OP_TOUCH_LD, CBM_OP_TOUCH_ST:
                            begin
                                if (!cur_attr_reg.xlate_ok || !cur_attr_reg.load_ok || !PREFETCH_EN)
                                begin
                                    stat_reg[CBM_ST_NOOP] <= 1'b1;
                                    state_reg <= CBM_S_DONE;
                                end
                                else
                                begin
                                    dc_req <= 1'b1;
                                    dc_cmd <= CBM_DC_PREFETCH;
                                    rc_rec <= 1'b1;
                                    rc_store <= 1'b0;
                                    state_reg <= CBM_S_LOCAL;
                                end
                            end
                            CBM_OP_ZERO:
                            begin
                                if (!cur_attr_reg.xlate_ok || !cur_attr_reg.store_ok)
                                begin
                                    stat_reg[CBM_ST_DSI] <= 1'b1;
                                    state_reg <= CBM_S_DONE;
                                end
                                else
                                begin
                                    rc_rec <= 1'b1;
                                    rc_store <= 1'b1;
                                    stat_reg[CBM_ST_RCSTORE] <= 1'b1;
                                    if (cur_attr_reg.i || cur_attr_reg.w)
                                    begin
                                        if (cur_attr_reg.align_mode)
                                        begin
                                            stat_reg[CBM_ST_ALIGN] <= 1'b1;
                                            state_reg <= CBM_S_DONE;
                                        end
                                        else
                                        begin
                                            mem_zero_req <= 1'b1;
                                            state_reg <= CBM_S_MEM;
                                        end
                                    end
                                    else
                                    begin
                                        dc_req <= 1'b1;
                                        dc_cmd <= CBM_DC_LOOKUP;
                                        state_reg <= CBM_S_LOOK;
                                    end
                                end
                            end
                            CBM_OP_STORE, CBM_OP_FLUSH:
                            begin
                                // W and I deliberately not consulted
                                rc_rec <= 1'b1;
                                rc_store <= 1'b0;
                                dc_req <= 1'b1;
                                dc_cmd <= CBM_DC_LOOKUP;
                                state_reg <= CBM_S_LOOK;
                            end
                            CBM_OP_ICBI:
                            begin
                                if (!cur_attr_reg.xlate_ok || !cur_attr_reg.load_ok)
                                begin
                                    stat_reg[CBM_ST_DSI] <= 1'b1;
                                    state_reg <= CBM_S_DONE;
                                end
                                else
                                begin
                                    rc_rec <= 1'b1;
                                    rc_store <= 1'b0;
                                    if (cur_attr_reg.unified)
                                    begin
                                        if (need_coh)
                                        begin
                                            coh_req <= 1'b1;
                                            coh_cmd <= coh_sel;
                                            state_reg <= CBM_S_COH;
                                        end
                                        else
                                        begin
                                            state_reg <= CBM_S_DONE;
                                        end
                                    end
                                    else
                                    begin
                                        ic_inv_req <= 1'b1;
                                        state_reg <= CBM_S_LOCAL;
                                    end
                                end
                            end
                            CBM_OP_ISYNC:
                            begin
                                hold_issue <= 1'b1;
                                state_reg <= CBM_S_SYNC;
                            end
                            default:
                            begin
                                state_reg <= CBM_S_DONE;
                            end
                        endcase
                    end
                end
                CBM_S_LOOK:
                begin
                    if (dc_ack)
                    begin
                        if (op_reg == CBM_OP_ZERO)
                        begin
                            // clear on hit, allocate without fetch on miss
                            dc_req <= 1'b1;
                            dc_cmd <= dc_resp.hit ? CBM_DC_ZERO : CBM_DC_ALLOC_ZERO;
                            state_reg <= CBM_S_LOCAL;
                        end
                        else if (dc_resp.hit && (dc_resp.modified || op_reg == CBM_OP_FLUSH))
                        begin
                            dc_req <= 1'b1;
                            stat_reg[CBM_ST_WROTE] <= dc_resp.modified;
                            if (op_reg == CBM_OP_STORE)
                            begin
                                dc_cmd <= CBM_DC_CLEAN;
                            end
                            else
                            begin
                                dc_cmd <= dc_resp.modified ? CBM_DC_FLUSH : CBM_DC_INV;
                            end
                            state_reg <= CBM_S_LOCAL;
                        end
                        // local miss takes no local action
                        else if (need_coh)
                        begin
                            coh_req <= 1'b1;
                            coh_cmd <= coh_sel;
                            state_reg <= CBM_S_COH;
                        end
                        else
                        begin
                            state_reg <= CBM_S_DONE;
                        end
                    end
                end
                CBM_S_LOCAL:
                begin
                    if (dc_ack || ic_ack)
                    begin
                        if (need_coh)
                        begin
                            coh_req <= 1'b1;
                            coh_cmd <= coh_sel;
                            state_reg <= CBM_S_COH;
                        end
                        else
                        begin
                            state_reg <= CBM_S_DONE;
                        end
                    end
                end
                CBM_S_COH:
                begin
                    // remote modified holder reports its write-back
                    if (coh_ack)
                    begin
                        if (coh_mod)
                        begin
                            stat_reg[CBM_ST_WROTE] <= 1'b1;
                        end
                        state_reg <= CBM_S_DONE;
                    end
                end
                CBM_S_MEM:
                begin
                    if (mem_ack)
                    begin
                        state_reg <= CBM_S_DONE;
                    end
                end
                CBM_S_SYNC:
                begin
                    // wait for drain, then discard prefetched
                    if (pipe_drained)
                    begin
                        fetch_discard <= 1'b1;
                        state_reg <= CBM_S_DONE;
                    end
                end
                CBM_S_DONE:
                begin
                    hold_issue <= 1'b0;
                    stat_reg[CBM_ST_BUSY] <= 1'b0;
                    stat_reg[CBM_ST_DONE] <= 1'b1;
                    state_reg <= CBM_S_IDLE;
                end
                default:
                begin
                    state_reg <= CBM_S_IDLE;
                end
            endcase
        end
    end

endmodule

// ==== cbm_block_ops_sva.sv ====
`timescale 1ns/1ps
module cbm_block_ops_sva #(parameter int BLOCK_BYTES = 32)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pipe_drained,
    input wire logic hold_issue,
    input wire logic fetch_discard,
    input wire logic dc_req,
    input wire logic coh_req,
    input wire logic ic_inv_req,
    input wire logic mem_zero_req,
    input wire logic [31:0] blk_addr
);
    // ==========
    // Port timing checks, one domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access cycle still waiting for the slave
    sequence acc_wait;
        psel && penable && !pready;
    endsequence
    ready_timing_a: assert property (acc_wait |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    slverr_qual_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    blk_align_a: assert property ((blk_addr & (BLOCK_BYTES - 1)) == 0) else $error("unaligned");
    isync_order_a: assert property (fetch_discard |-> pipe_drained && hold_issue) else $error("early");
    sync_hold_a: assert property (hold_issue && !fetch_discard |=> hold_issue) else $error("hold dropped");
    discard_pulse_a: assert property (fetch_discard |=> !fetch_discard) else $error("discard held");
    icinv_pulse_a: assert property (ic_inv_req |=> !ic_inv_req) else $error("icinv held");
    zero_mem_a: assert property (mem_zero_req |-> !dc_req ##1 !mem_zero_req) else $error("memzero");
    coh_pulse_a: assert property (coh_req |=> !coh_req) else $error("coh held");
endmodule

// ==== cbm_far_model.sv ====
`timescale 1ns/1ps
module cbm_far_model
    import cbm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dc_req,
    input wire logic ic_inv_req,
    input wire logic coh_req,
    input wire logic mem_zero_req,
    input wire logic rmod,
    input wire cbm_dc_resp_type resp,
    output logic dc_ack,
    output logic ic_ack,
    output logic coh_ack,
    output logic mem_ack,
    output logic coh_mod,
    output cbm_dc_resp_type dc_resp
);
    // ==========
    // Caches and memory answer one cycle after each request
    // remote caches act then acknowledge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn) {dc_ack, ic_ack, coh_ack, mem_ack} <= 4'h0;
        else {dc_ack, ic_ack, coh_ack, mem_ack} <= {dc_req, ic_inv_req, coh_req, mem_zero_req};
    end
    // Outside the ack cycle the lines show garbage, never stale truth
    assign dc_resp = dc_ack ? resp : cbm_dc_resp_type'(~resp);
    assign coh_mod = coh_ack ? rmod : ~rmod;
endmodule

// ==== cbm_block_ops_tb.sv ====
`timescale 1ns/1ps
module cbm_block_ops_tb;
    import cbm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pipe_drained = 1, rmod = 0, slverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rdata;
    logic [15:0] seen = 16'h0; // Far-side requests seen, by kind
    cbm_dc_resp_type resp = '0;
    wire logic [31:0] prdata, blk_addr;
    wire logic pready, pslverr, hold_issue, fetch_discard, dc_req, dc_ack, ic_inv_req, ic_ack;
    wire logic coh_req, coh_ack, coh_mod, mem_zero_req, mem_ack, rc_rec, rc_store;
    wire cbm_dc_cmd_type dc_cmd;
    wire cbm_coh_cmd_type coh_cmd;
    wire cbm_dc_resp_type dc_resp;
    int n_mismatch = 0, n_compared = 0;
    always #10 pclk = ~pclk;
    cbm_block_ops #(.BLOCK_BYTES(32)) dut_u (.*);
    cbm_far_model far_u (.*);
    // ==========
    // Request log, cleared by the tasks just before each operation start; bits 0 and 8 log load and store recording
    always @(posedge pclk)
    begin
        if (rc_rec) seen[rc_store ? 8 : 0] <= 1'b1;
        if (dc_req) seen[dc_cmd] <= 1'b1;
        if (coh_req) seen[8 + coh_cmd] <= 1'b1;
        if (ic_inv_req) seen[13] <= 1'b1;
        if (fetch_discard) seen[14] <= 1'b1;
        if (mem_zero_req) seen[15] <= 1'b1;
    end
    task give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // APB master, holds the request until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        {rdata, slverr} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (k == 20)
        begin
            n_mismatch++;
            give_verdict;
        end
    endtask
    task wait_done;
        int k;
        for (k = 0; k < 40; k++)
        begin
            apb(0, CBM_OFF_STAT, 0);
            if (rdata[1] === 1'b1) break;
        end
        if (k == 40)
        begin
            n_mismatch++;
            give_verdict;
        end
    endtask
    // Start one operation, then judge requests, status and block address
    task run_op(input cbm_op_type op, input logic [8:0] at, input logic [1:0] hm, input logic rm,
                input logic [15:0] es, input logic [6:0] ex, input logic [6:0] mk);
        {resp, rmod} <= {hm, rm};
        apb(1, CBM_OFF_STAT, 32'h2);
        apb(1, CBM_OFF_ADDR, 32'h1234_567b);
        apb(1, CBM_OFF_ATTR, 32'(at));
        seen <= 16'h0;
        apb(1, CBM_OFF_CMD, 32'(op));
        wait_done;
        chk(32'(seen), 32'(es));
        chk(32'(rdata[6:0] & mk), 32'(ex & mk));
        chk(blk_addr, 32'h1234_5660);
    endtask
    task t_bus;
        apb(0, CBM_OFF_ATTR, 0);
        chk(rdata, 32'(CBM_ATTR_RESET));
        apb(1, 8'h10, 32'h5);
        chk(32'(slverr), 1);
        apb(1, CBM_OFF_CMD, 32'h7);
        chk(32'(slverr), 1);
        apb(0, CBM_OFF_STAT, 0);
        chk(rdata, 32'h0);
    endtask
    task t_touch;
        run_op(CBM_OP_TOUCH_LD, 9'h030, 2'b00, 0, 16'h0005, 7'h02, 7'h7e);
        run_op(CBM_OP_TOUCH_ST, 9'h010, 2'b00, 0, 16'h0000, 7'h12, 7'h3e);
    endtask
    task t_zero;
        run_op(CBM_OP_ZERO, 9'h074, 2'b10, 0, 16'h030a, 7'h42, 7'h7e);
        run_op(CBM_OP_ZERO, 9'h070, 2'b00, 0, 16'h0112, 7'h42, 7'h7e);
        run_op(CBM_OP_ZERO, 9'h072, 2'b00, 0, 16'h8100, 7'h42, 7'h5e);
        run_op(CBM_OP_ZERO, 9'h172, 2'b00, 0, 16'h0100, 7'h0a, 7'h1e);
        run_op(CBM_OP_ZERO, 9'h030, 2'b00, 0, 16'h0000, 7'h06, 7'h7e);
        run_op(CBM_OP_ZERO, 9'h07c, 2'b10, 0, 16'h0000, 7'h12, 7'h3e);
    endtask
    task t_store_flush;
        run_op(CBM_OP_STORE, 9'h037, 2'b11, 0, 16'h0423, 7'h22, 7'h7e);
        run_op(CBM_OP_STORE, 9'h030, 2'b10, 0, 16'h0003, 7'h02, 7'h7e);
        run_op(CBM_OP_STORE, 9'h030, 2'b11, 0, 16'h0023, 7'h22, 7'h7e);
        run_op(CBM_OP_FLUSH, 9'h034, 2'b11, 0, 16'h0883, 7'h22, 7'h7e);
        run_op(CBM_OP_FLUSH, 9'h034, 2'b10, 0, 16'h0843, 7'h02, 7'h7e);
        run_op(CBM_OP_FLUSH, 9'h034, 2'b00, 1, 16'h0803, 7'h22, 7'h7e);
        run_op(CBM_OP_FLUSH, 9'h030, 2'b10, 0, 16'h0043, 7'h02, 7'h7e);
        run_op(CBM_OP_FLUSH, 9'h030, 2'b00, 0, 16'h0003, 7'h02, 7'h7e);
    endtask
    task t_icbi;
        run_op(CBM_OP_ICBI, 9'h034, 2'b00, 0, 16'h3001, 7'h02, 7'h2e);
        run_op(CBM_OP_ICBI, 9'h030, 2'b00, 0, 16'h2001, 7'h02, 7'h2e);
        run_op(CBM_OP_ICBI, 9'h0b0, 2'b00, 0, 16'h0001, 7'h02, 7'h2e);
        run_op(CBM_OP_ICBI, 9'h0b4, 2'b00, 0, 16'h1001, 7'h02, 7'h2e);
        run_op(CBM_OP_ICBI, 9'h010, 2'b00, 0, 16'h0000, 7'h06, 7'h2e);
    endtask
    // Isync must stall while earlier work is still draining
    task t_isync;
        pipe_drained <= 1'b0;
        apb(1, CBM_OFF_STAT, 32'h2);
        seen <= 16'h0;
        apb(1, CBM_OFF_CMD, 32'(CBM_OP_ISYNC));
        repeat (10) @(posedge pclk);
        chk(32'(hold_issue), 1);
        chk(32'(seen), 0);
        pipe_drained <= 1'b1;
        wait_done;
        chk(32'(seen), 32'h4000);
    endtask
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_bus;
        t_touch;
        t_zero;
        t_store_flush;
        t_icbi;
        t_isync;
        give_verdict;
    end
endmodule
bind cbm_block_ops cbm_block_ops_sva #(.BLOCK_BYTES(BLOCK_BYTES)) sva_u (.*);
